// *** rtl/gdio_port_map.vh ***
// Purpose: Register offsets, reset values and widths of the I/O port
// Assumes: Included by the port module only
// Notes:   Offsets are relative to the port base parameter
`ifndef GDIO_PORT_MAP_VH
`define GDIO_PORT_MAP_VH

// Port width in pins
`define GDIO_PINS            8
`define GDIO_ADDR_W          6

// Register offsets from the port base
`define GDIO_OFS_INPUT_LEVEL 6'h00
`define GDIO_OFS_DIRECTION   6'h01
`define GDIO_OFS_OUTPUT_VAL  6'h02

// Reset values
`define GDIO_RST_DIRECTION   8'h00
`define GDIO_RST_OUTPUT_VAL  8'h00
`define GDIO_RST_INPUT_LEVEL 8'h00
`define GDIO_RST_RDATA       8'h00
`define GDIO_UNMAPPED_RDATA  8'h00

// Pin enable levels (output enable is active low)
`define GDIO_OE_N_OFF        8'hFF

`endif

// *** rtl/gdio_port.v ***
// Purpose: One eight-pin general digital I/O port with its three registers
// Assumes: Core I/O bus with byte and single-bit access, core_clk at 10 MHz
// Notes:   Pin drive and pull-up flops clear without a clock so pins float
//
// Overview of operation
// - Single-bit set or clear leaves other pins
// - Three I/O addresses per port
// - Input register read-only; others read-write
// - Global pull-up off kills all but override pull-ups
// - Direction one output, zero input
// - Input with value one enables pull-up
// - Reset tri-states pins without a clock
// - Output pin drives its value bit
// - Input level readable whatever the direction
// - Latch holds at fall, register loads rising
// - Pin change seen after half to 1.5 periods
// - Written value reaches input one period later
// - Alternate function leaves other pins usable
// - Deep sleep clamps input unless overridden
// - Pull-up only for dir0, value1, global off0 unless overridden
`include "gdio_port_map.vh"
`timescale 1ns/10ps

module gdio_port
#(
    parameter [`GDIO_ADDR_W-1:0] PORT_BASE = 6'h10,
    parameter                    PINS      = `GDIO_PINS
)
(
    input  wire                    core_clk,
    input  wire                    rstn,
    input  wire                    clkEn,
    input  wire [`GDIO_ADDR_W-1:0] ioAddr,
    input  wire                    ioWr,
    input  wire [PINS-1:0]         ioWrData,
    input  wire                    ioSetBit,
    input  wire                    ioClrBit,
    input  wire [2:0]              ioBitIdx,
    input  wire                    ioRd,
    output reg  [PINS-1:0]         ioRdData_ff,
    input  wire                    globalPullupOff,
    input  wire                    sleepClamp,
    input  wire [PINS-1:0]         sleepOverride,
    input  wire [PINS-1:0]         pullupOvrEn,
    input  wire [PINS-1:0]         pullupOvrVal,
    input  wire [PINS-1:0]         padIn,
    output reg  [PINS-1:0]         padOut_ff,
    output reg  [PINS-1:0]         padOeN_ff,
    output reg  [PINS-1:0]         pullupEn_ff
);

    reg  [PINS-1:0] dirReg_ff;
    reg  [PINS-1:0] outReg_ff;
    reg  [PINS-1:0] syncLatch_ff;
    reg  [PINS-1:0] inLevel_ff;
    reg  [PINS-1:0] nxt_dirReg;
    reg  [PINS-1:0] nxt_outReg;
    reg  [PINS-1:0] nxt_pullup;
    reg  [PINS-1:0] nxt_rdData;
    reg  [PINS-1:0] bitMask;
    wire [PINS-1:0] digIn;
    wire            hitIn;
    wire            hitDir;
    wire            hitOut;

    // Address decode, one location per register
    assign hitIn  = (ioAddr == PORT_BASE + `GDIO_OFS_INPUT_LEVEL);
    assign hitDir = (ioAddr == PORT_BASE + `GDIO_OFS_DIRECTION);
    assign hitOut = (ioAddr == PORT_BASE + `GDIO_OFS_OUTPUT_VAL);

    // Register writes: whole byte or a single bit
    always @*
    begin
        bitMask    = {{(PINS-1){1'b0}}, 1'b1} << ioBitIdx;
        nxt_dirReg = dirReg_ff;
        nxt_outReg = outReg_ff;
        if (hitDir)
        begin
            if (ioWr)
                nxt_dirReg = ioWrData;
            else if (ioSetBit)
                nxt_dirReg = dirReg_ff | bitMask;
            else if (ioClrBit)
                nxt_dirReg = dirReg_ff & ~bitMask;
        end
        else if (hitOut)
        begin
            if (ioWr)
                nxt_outReg = ioWrData;
            else if (ioSetBit)
                nxt_outReg = outReg_ff | bitMask;
            else if (ioClrBit)
                nxt_outReg = outReg_ff & ~bitMask;
        end
        // Writes to the input location fall through untouched
    end

    // Pull-up only for input, value one, global off clear, unless overridden
    always @*
    begin
        nxt_pullup = ~nxt_dirReg & nxt_outReg
                   & {PINS{~globalPullupOff}};
        // Alternate function takes the pull-up of its own pins only
        nxt_pullup = (pullupOvrEn & pullupOvrVal)
                   | (~pullupOvrEn & nxt_pullup);
    end

    // Read mux; unmapped offsets answer zero
    always @*
    begin
        if (hitIn)
            nxt_rdData = inLevel_ff;
        else if (hitDir)
            nxt_rdData = dirReg_ff;
        else if (hitOut)
            nxt_rdData = outReg_ff;
        else
            nxt_rdData = `GDIO_UNMAPPED_RDATA;
    end

    // Configuration registers and read data
    always @(posedge core_clk)
    begin
        if (!rstn)
        begin
            dirReg_ff   <= `GDIO_RST_DIRECTION;
            outReg_ff   <= `GDIO_RST_OUTPUT_VAL;
            ioRdData_ff <= `GDIO_RST_RDATA;
        end
        else if (clkEn)
        begin
            dirReg_ff <= nxt_dirReg;
            outReg_ff <= nxt_outReg;
            if (ioRd)
                ioRdData_ff <= nxt_rdData;
        end
    end

    // Pin drivers take next values so the pin moves with the register.
    // Cleared without a clock: pins must float even with a dead clock.
    always @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            padOeN_ff   <= `GDIO_OE_N_OFF;
            padOut_ff   <= `GDIO_RST_OUTPUT_VAL;
            pullupEn_ff <= {PINS{1'b0}};
        end
        else if (clkEn)
        begin
            padOeN_ff   <= ~nxt_dirReg;
            padOut_ff   <= nxt_outReg;
            pullupEn_ff <= nxt_pullup;
        end
    end

    // Deep sleep forces the digital input low ahead of the latch
    assign digIn = padIn & ~({PINS{sleepClamp}} & ~sleepOverride);

    // Latch stage: tracks while clock high, holds from the falling edge.
    // Modelled as a falling-edge flop, which gives the same held value.
    always @(negedge core_clk)
    begin
        if (!rstn)
            syncLatch_ff <= `GDIO_RST_INPUT_LEVEL;
        else if (clkEn)
            syncLatch_ff <= digIn;
    end

    // Input register loads the held value at the next rising edge
    always @(posedge core_clk)
    begin
        if (!rstn)
            inLevel_ff <= `GDIO_RST_INPUT_LEVEL;
        else if (clkEn)
            inLevel_ff <= syncLatch_ff;
    end

endmodule // gdio_port

// *** verification/gdio_port_assertions.sv ***
// Purpose: Pin and bus checks of the port
// Assumes: Bound into gdio_port
// Notes:   Float check ignores the reset disable
`timescale 1ns/10ps
module gdio_port_assertions #(parameter [5:0] PORT_BASE = 6'h10,
    parameter PINS = 8) (input wire core_clk, rstn, clkEn, ioWr, ioSetBit,
    ioClrBit, ioRd, globalPullupOff, input wire [5:0] ioAddr,
    input wire [2:0] ioBitIdx, input wire [PINS-1:0] ioWrData, ioRdData_ff,
    padOut_ff, padOeN_ff, pullupEn_ff, pullupOvrEn, pullupOvrVal);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    // Decoded requests; a byte write outranks set and clear
    wire [5:0] ofs = ioAddr - PORT_BASE;
    wire wr = clkEn & ioWr, st = clkEn & ~ioWr & ioSetBit;
    wire cl = clkEn & ~ioWr & ~ioSetBit & ioClrBit, rdo = clkEn & ioRd & ~ioWr;
    wire [7:0] msk = 8'h01 << ioBitIdx;
    dir_write_a: assert property (wr && ofs == 1 |=>
        padOeN_ff == ~$past(ioWrData)) else $error("dir write");
    out_write_a: assert property (wr && ofs == 2 |=>
        padOut_ff == $past(ioWrData)) else $error("out write");
    bit_set_a: assert property (st && ofs == 1 |=>
        padOeN_ff == ($past(padOeN_ff) & ~$past(msk))) else $error("set");
    bit_clear_a: assert property (cl && ofs == 2 |=>
        padOut_ff == ($past(padOut_ff) & ~$past(msk))) else $error("clr");
    dir_read_a: assert property (rdo && ofs == 1 |=>
        ioRdData_ff == ~$past(padOeN_ff)) else $error("dir read");
    unmapped_read_a: assert property (clkEn && ioRd && ofs > 2 |=>
        ioRdData_ff == 8'h00) else $error("unmapped");
    pullup_mix_a: assert property ($past(clkEn) && $past(rstn) |->
        pullupEn_ff == ($past(pullupOvrEn) & $past(pullupOvrVal) |
        ~$past(pullupOvrEn) & padOeN_ff & padOut_ff &
        ~{PINS{$past(globalPullupOff)}})) else $error("pull-up");
    reset_float_a: assert property (disable iff (1'b0)
        !rstn [*2] |-> padOeN_ff == 8'hFF && pullupEn_ff == 8'h00)
        else $error("float");
    cover property (st && ofs == 1);
    cover property (cl && ofs == 2);
    cover property (wr && ofs == 0);
endmodule // gdio_port_assertions
bind gdio_port gdio_port_assertions #(.PORT_BASE(PORT_BASE), .PINS(PINS))
    u_chk (.*);

// *** verification/gdio_pin_model.sv ***
// Purpose: Board side of the eight port pins
// Assumes: Bench picks driven pins and levels
// Notes:   Released pins toggle so a float never looks valid
`timescale 1ns/10ps
module gdio_pin_model (input wire core_clk, input wire [7:0] padOut_ff,
    padOeN_ff, pullupEn_ff, extDrv, extVal, output wire [7:0] padIn);
    reg floatLvl_ff = 1'b0;
    // Free toggle for released lines
    always @(posedge core_clk)
        floatLvl_ff <= ~floatLvl_ff;
    // Port drive first, then board drive, then pull-up
    assign padIn = ~padOeN_ff & padOut_ff | padOeN_ff & (extDrv & extVal
        | ~extDrv & (pullupEn_ff | {8{floatLvl_ff}}));
endmodule // gdio_pin_model

// *** verification/tb_gdio_port.sv ***
// Purpose: Self-checking bench of the port
// Assumes: Base 6'h10, clkEn high except for one frozen byte write
// Notes:   Pads compared as one 24-bit word
`timescale 1ns/10ps
module tb_gdio_port;
    localparam [5:0] B = 6'h10;
    reg core_clk = 0, rstn = 1, clkEn = 1, ioWr = 0, ioSetBit = 0;
    reg ioClrBit = 0, ioRd = 0, globalPullupOff = 0, sleepClamp = 0;
    reg [5:0] ioAddr = 0;
    reg [2:0] ioBitIdx = 0;
    reg [7:0] ioWrData = 0, sleepOverride = 0, pullupOvrEn = 0;
    reg [7:0] pullupOvrVal = 0, extDrv = 0, extVal = 0;
    wire [7:0] ioRdData_ff, padIn, padOut_ff, padOeN_ff, pullupEn_ff;
    integer nErrors = 0, checks = 0;
    always #50 core_clk = ~core_clk;
    gdio_port #(.PORT_BASE(B)) u_dut (.*);
    gdio_pin_model u_pins (.*);
    task chk(input [23:0] s, e);
        checks = checks + 1;
        if (s !== e)
        begin
            nErrors = nErrors + 1;
            $display("wrong value at %0t: %h vs %h", $time, s, e);
        end
    endtask
    // Held to its taking edge; k is {wr,set,clr,rd}
    task rq(input [3:0] k, input [5:0] a, input [7:0] d, input [2:0] i);
        @(posedge core_clk);
        {ioWr, ioSetBit, ioClrBit, ioRd} <= k;
        {ioAddr, ioWrData, ioBitIdx} <= {a, d, i};
        @(posedge core_clk);
        {ioWr, ioSetBit, ioClrBit, ioRd} <= 4'h0;
        #1;
    endtask
    task rd(input [5:0] a, input [7:0] e);
        rq(4'h1, a, 8'h00, 3'h0);
        chk(ioRdData_ff, e);
    endtask
    task results;
        $display("checks %0d errors %0d", checks, nErrors);
        if (nErrors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Run needs some 65 cycles
    initial
    begin
        #100000 nErrors = nErrors + 1;
        results;
    end
    initial
    begin
        #10 rstn = 0;
        #10 chk(padOeN_ff & ~pullupEn_ff, 8'hFF);
        repeat (20) @(posedge core_clk);
        rstn <= 1;
        rq(4'h8, B + 6'h2, 8'hC3, 3'h0);
        rq(4'h8, B + 6'h1, 8'h0F, 3'h0);
        chk({padOeN_ff, padOut_ff, pullupEn_ff}, 24'hF0C3C0);
        rd(B + 6'h1, 8'h0F);
        @(posedge core_clk) globalPullupOff <= 1;
        @(posedge core_clk) #1 chk(pullupEn_ff, 8'h00);
        @(posedge core_clk) globalPullupOff <= 0;
        rq(4'h4, B + 6'h1, 8'h00, 3'h6);
        rq(4'h2, B + 6'h2, 8'h00, 3'h6);
        chk({padOeN_ff, padOut_ff, pullupEn_ff}, 24'hB08380);
        rq(4'h8, B, 8'hFF, 3'h0);
        rd(B + 6'h1, 8'h4F);
        rd(B + 6'h3, 8'h00);
        @(posedge core_clk) {extDrv, extVal} <= 16'hB020;
        rq(4'h8, B + 6'h2, 8'h4A, 3'h0);
        rd(B, 8'h6A);
        @(posedge core_clk) extVal <= 8'h90;
        rd(B, 8'hDA);
        @(posedge core_clk) {sleepClamp, sleepOverride} <= 9'h180;
        rd(B, 8'h80);
        @(posedge core_clk) {sleepClamp, pullupOvrEn, pullupOvrVal} <= 17'h101;
        @(posedge core_clk) #1 chk(pullupEn_ff, 8'h01);
        // Frozen clock enable must swallow a byte write
        @(posedge core_clk) clkEn <= 0;
        rq(4'h8, B + 6'h2, 8'h00, 3'h0);
        chk(padOut_ff, 8'h4A);
        @(posedge core_clk) clkEn <= 1;
        // Mid-run reset floats pins at once, then regs read clear
        @(posedge core_clk) rstn <= 0;
        #1 chk({padOeN_ff, padOut_ff, pullupEn_ff}, 24'hFF0000);
        repeat (2) @(posedge core_clk);
        rstn <= 1;
        rd(B + 6'h1, 8'h00);
        rd(B + 6'h2, 8'h00);
        results;
    end
endmodule // tb_gdio_port
